// >>> ilw_seq.sv
// ilw_seq: interrupt latency, wake-up and external pin sequencer
// assumes a core that runs one instruction cycle per four clocks,
// honours flush/stall/pc_load and samples outputs only while CE_I is high
//
// Notes on behaviour
// - synchronous event reaches vector in 3-4 cycles
// - asynchronous event reaches vector in 3-5 cycles
// - latency same for one or two-cycle instructions
// - pin flag may set only in phases four/one
// - only clockless sources may wake from sleep
// - wake needs enables set before sleep entry
// - wake with global enable set goes to vector
// - wake with global enable clear resumes sequentially
// - instruction after sleep runs before any branch
// - pin interrupt edge triggered, gated by its enable
// - edge select: one rising, zero falling
// - valid selected edge sets the pin flag
// - flag plus both enables redirects to vector
// - only the return address is pushed
// - take: flush, clear enable, push, load vector
// - flags set regardless of any enable
// - return pops address and sets global enable
// - reset clears every enable bit
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ilw_seq #(
	parameter int NPER = 4,
	parameter logic [NPER-1:0] WAKE_MASK = 4'b0001
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	input wire logic CE_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic EXT_PIN_I,
	input wire logic [NPER-1:0] PERIPH_FLAG_I,
	input wire ilw_pkg::ilw_core_s CORE_I,
	output ilw_pkg::ilw_ctl_s CTL_O,
	output logic [1:0] PHASE_O,
	output logic IRQ_O
);
	logic ce;
	logic wr;
	logic [7:0] addr;
	logic [31:0] rdata;
	logic [1:0] phase;
	logic edge_pulse;
	logic global_irq_enable;
	logic ext_pin_irq_enable;
	logic ext_edge_select;
	logic per_enable;
	logic [NPER-1:0] per_en;
	logic ext_pin_irq_flag;
	logic edge_hold;
	logic snap_ext;
	logic [NPER-1:0] snap_per;
	logic pend_q1;
	logic any_req;
	logic wake_pend;
	logic window;
	logic take;
	logic ret_take;
	logic [ilw_pkg::EV_N-1:0] ev;
	logic [ilw_pkg::EV_N-1:0] ev_stat;
	logic [ilw_pkg::EV_N-1:0] ev_en;
	logic [ilw_pkg::EV_N-1:0] next_ev_stat;
	ilw_pkg::ilw_seq_e seq;
	ilw_pkg::ilw_seq_e next_seq;

	assign ce = CE_I;
	assign PHASE_O = phase; // straight from the phase flops
	assign HRESP_O = 1'b0;

	// ****************************************************************
	// bus slave and pin edge detector
	// ****************************************************************
	ilw_ahb_slave u_bus (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.ce_i(ce),
		.hsel_i(HSEL_I),
		.haddr_i(HADDR_I),
		.htrans_i(HTRANS_I),
		.hwrite_i(HWRITE_I),
		.hready_i(HREADY_I),
		.rdata_i(rdata),
		.hrdata_o(HRDATA_O),
		.hreadyout_o(HREADYOUT_O),
		.wr_o(wr),
		.addr_o(addr)
	);

	ilw_pin_edge u_pin (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.ce_i(ce),
		.pin_i(EXT_PIN_I),
		.rising_i(ext_edge_select),
		.edge_o(edge_pulse)
	);

	// ****************************************************************
	// instruction cycle phase counter
	// ****************************************************************
	// parks on phase one while asleep so a wake starts a whole cycle
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			phase <= ilw_pkg::PHASE_ONE;
		end else if (ce) begin
			if (next_seq == ilw_pkg::S_SLEEP || seq == ilw_pkg::S_SLEEP) begin
				phase <= ilw_pkg::PHASE_ONE;
			end else begin
				phase <= phase + 2'h1;
			end
		end
	end

	// ****************************************************************
	// control and enable bits
	// ****************************************************************
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			global_irq_enable <= ilw_pkg::CTRL_RST[ilw_pkg::CTRL_GLOBAL_EN];
			ext_pin_irq_enable <= ilw_pkg::CTRL_RST[ilw_pkg::CTRL_EXT_EN];
			ext_edge_select <= ilw_pkg::CTRL_RST[ilw_pkg::CTRL_EDGE_SEL];
			per_enable <= ilw_pkg::CTRL_RST[ilw_pkg::CTRL_PER_EN];
			per_en <= '0;
		end else if (ce) begin
			if (wr && addr == ilw_pkg::CTRL_OFS) begin
				global_irq_enable <= HWDATA_I[ilw_pkg::CTRL_GLOBAL_EN];
				ext_pin_irq_enable <= HWDATA_I[ilw_pkg::CTRL_EXT_EN];
				ext_edge_select <= HWDATA_I[ilw_pkg::CTRL_EDGE_SEL];
				per_enable <= HWDATA_I[ilw_pkg::CTRL_PER_EN];
			end
			if (wr && addr == ilw_pkg::PER_EN_OFS) begin
				per_en <= HWDATA_I[NPER-1:0];
			end
			// hardware wins over a software write in the same cycle
			if (take) begin
				global_irq_enable <= 1'b0;
			end else if (ret_take) begin
				global_irq_enable <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// external pin flag
	// ****************************************************************
	assign window = phase == ilw_pkg::PHASE_FOUR || phase == ilw_pkg::PHASE_ONE;

	// edge held until the phase four/one window, set beats clear
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			edge_hold <= 1'b0;
			ext_pin_irq_flag <= 1'b0;
		end else if (ce) begin
			edge_hold <= (edge_hold || edge_pulse) && !window;
			if ((edge_hold || edge_pulse) && window) begin
				ext_pin_irq_flag <= 1'b1;
			end else if (wr && addr == ilw_pkg::FLAG_OFS &&
				HWDATA_I[ilw_pkg::FLAG_EXT]) begin
				ext_pin_irq_flag <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// request, wake and snapshot logic
	// ****************************************************************
	assign any_req = (ext_pin_irq_flag && ext_pin_irq_enable) ||
		(per_enable && |(PERIPH_FLAG_I & per_en));
	// only clockless sources whose enables were set at sleep entry
	assign wake_pend = (ext_pin_irq_flag && snap_ext) ||
		|(PERIPH_FLAG_I & snap_per & WAKE_MASK);

	// request sampled once per instruction cycle, in phase one
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pend_q1 <= 1'b0;
			snap_ext <= 1'b0;
			snap_per <= '0;
		end else if (ce) begin
			if (phase == ilw_pkg::PHASE_ONE) begin
				pend_q1 <= global_irq_enable && any_req;
			end
			if (seq != ilw_pkg::S_SLEEP && next_seq == ilw_pkg::S_SLEEP) begin
				snap_ext <= ext_pin_irq_enable;
				snap_per <= per_enable ? per_en : '0;
			end
		end
	end

	// ****************************************************************
	// sequencer
	// ****************************************************************
	// fixed cycle counts from the phase-one sample keep the latency the
	// same for one and two-cycle instructions: the second cycle is flushed
	always_comb begin
		next_seq = seq;
		unique case (seq)
			ilw_pkg::S_RUN: begin
				if (phase == ilw_pkg::PHASE_FOUR) begin
					if (CORE_I.sleep_req) begin
						next_seq = ilw_pkg::S_SLEEP;
					end else if (pend_q1) begin
						next_seq = ilw_pkg::S_FLUSH;
					end
				end
			end
			ilw_pkg::S_FLUSH: begin
				if (phase == ilw_pkg::PHASE_FOUR) begin
					next_seq = ilw_pkg::S_VECTOR;
				end
			end
			ilw_pkg::S_VECTOR: begin
				if (phase == ilw_pkg::PHASE_FOUR) begin
					next_seq = ilw_pkg::S_RUN;
				end
			end
			ilw_pkg::S_SLEEP: begin
				if (wake_pend) begin
					next_seq = ilw_pkg::S_WAKE;
				end
			end
			ilw_pkg::S_WAKE: begin
				if (phase == ilw_pkg::PHASE_FOUR) begin
					if (global_irq_enable && any_req) begin
						next_seq = ilw_pkg::S_FLUSH;
					end else begin
						next_seq = ilw_pkg::S_RUN;
					end
				end
			end
		endcase
	end

	assign take = next_seq == ilw_pkg::S_FLUSH && seq != ilw_pkg::S_FLUSH;
	assign ret_take = seq == ilw_pkg::S_RUN && CORE_I.ret_irq;

	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			seq <= ilw_pkg::S_RUN;
		end else if (ce) begin
			seq <= next_seq;
		end
	end

	// ****************************************************************
	// core controls
	// ****************************************************************
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			CTL_O <= '0;
		end else if (ce) begin
			CTL_O.flush <= take;
			CTL_O.push <= take;
			CTL_O.push_addr <= CORE_I.pc;
			CTL_O.pop <= ret_take;
			CTL_O.pc_load <= ret_take || (seq == ilw_pkg::S_VECTOR &&
				phase == ilw_pkg::PHASE_FOUR);
			CTL_O.load_addr <= ret_take ? CORE_I.stack_top :
				ilw_pkg::VECTOR_ADDR;
			CTL_O.stall <= next_seq == ilw_pkg::S_FLUSH ||
				next_seq == ilw_pkg::S_VECTOR;
			CTL_O.sleep <= next_seq == ilw_pkg::S_SLEEP;
		end
	end

	// ****************************************************************
	// event status, clear and enable; interrupt output
	// ****************************************************************
	assign ev = {edge_pulse, seq == ilw_pkg::S_SLEEP &&
		next_seq == ilw_pkg::S_WAKE, take};
	// a new event wins over a clear in the same cycle
	assign next_ev_stat = ((wr && addr == ilw_pkg::EV_CLR_OFS) ?
		(ev_stat & ~HWDATA_I[ilw_pkg::EV_N-1:0]) : ev_stat) | ev;

	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ev_stat <= '0;
			ev_en <= '0;
			IRQ_O <= 1'b0;
		end else if (ce) begin
			ev_stat <= next_ev_stat;
			if (wr && addr == ilw_pkg::EV_EN_OFS) begin
				ev_en <= HWDATA_I[ilw_pkg::EV_N-1:0];
				IRQ_O <= |(next_ev_stat & HWDATA_I[ilw_pkg::EV_N-1:0]);
			end else begin
				IRQ_O <= |(next_ev_stat & ev_en);
			end
		end
	end

	// ****************************************************************
	// register read mux; unmapped and write-only offsets read zero
	// ****************************************************************
	always_comb begin
		rdata = 32'h0000_0000;
		unique case (addr)
			ilw_pkg::CTRL_OFS: begin
				rdata[ilw_pkg::CTRL_GLOBAL_EN] = global_irq_enable;
				rdata[ilw_pkg::CTRL_EXT_EN] = ext_pin_irq_enable;
				rdata[ilw_pkg::CTRL_EDGE_SEL] = ext_edge_select;
				rdata[ilw_pkg::CTRL_PER_EN] = per_enable;
			end
			ilw_pkg::PER_EN_OFS: rdata[NPER-1:0] = per_en;
			ilw_pkg::FLAG_OFS: begin
				rdata[ilw_pkg::FLAG_EXT] = ext_pin_irq_flag;
				rdata[ilw_pkg::FLAG_PER_LSB +: NPER] = PERIPH_FLAG_I;
			end
			ilw_pkg::EV_STAT_OFS: rdata[ilw_pkg::EV_N-1:0] = ev_stat;
			ilw_pkg::EV_EN_OFS: rdata[ilw_pkg::EV_N-1:0] = ev_en;
			ilw_pkg::SEQ_STAT_OFS: begin
				rdata[2:0] = seq;
				rdata[ilw_pkg::SEQ_PEND] = pend_q1;
				rdata[ilw_pkg::SEQ_PHASE_LSB +: 2] = phase;
			end
			default: rdata = 32'h0000_0000;
		endcase
	end

	// ****************************************************************
	// assertions and covers
	// ****************************************************************
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);

	take_clears_a: assert property (CTL_O.flush |-> CTL_O.push &&
		!global_irq_enable) else $error("take did not clear enable");
	vec_path_a: assert property (ce && seq == ilw_pkg::S_FLUSH &&
		phase == ilw_pkg::PHASE_FOUR |=> seq == ilw_pkg::S_VECTOR)
		else $error("flush not followed by vector cycle");
	vec_load_a: assert property (ce && seq == ilw_pkg::S_VECTOR &&
		phase == ilw_pkg::PHASE_FOUR |=> CTL_O.pc_load &&
		CTL_O.load_addr == 16'h0004) else $error("vector not loaded");
	sample_take_a: assert property (ce && seq == ilw_pkg::S_RUN &&
		phase == ilw_pkg::PHASE_FOUR && pend_q1 && !CORE_I.sleep_req
		|=> CTL_O.flush) else $error("pending request not taken");
	pin_window_a: assert property ($rose(ext_pin_irq_flag) |->
		$past(phase) == 2'h3 || $past(phase) == 2'h0)
		else $error("pin flag set outside window");
	sleep_hold_a: assert property (ce && seq == ilw_pkg::S_SLEEP &&
		!wake_pend |=> seq == ilw_pkg::S_SLEEP) else $error("false wake");
	wake_next_a: assert property (seq == ilw_pkg::S_WAKE |->
		!CTL_O.stall) else $error("branch before next instruction");
	wake_resume_a: assert property (ce && seq == ilw_pkg::S_WAKE &&
		phase == ilw_pkg::PHASE_FOUR && !global_irq_enable
		|=> seq == ilw_pkg::S_RUN && !CTL_O.flush)
		else $error("vectored with enable clear");
	ret_path_a: assert property (ce && ret_take |=> CTL_O.pop &&
		CTL_O.pc_load && global_irq_enable) else $error("return failed");

	vec_taken_c: cover property (CTL_O.flush ##[1:20] CTL_O.pc_load);
	wake_vec_c: cover property (seq == ilw_pkg::S_WAKE ##[1:8]
		seq == ilw_pkg::S_FLUSH);
	wake_run_c: cover property (seq == ilw_pkg::S_WAKE ##[1:8]
		seq == ilw_pkg::S_RUN);
	ret_c: cover property (CTL_O.pop);

endmodule
`default_nettype wire

// >>> ilw_pkg.sv
// ilw_pkg: constants, types and register map of the interrupt sequencer
// assumes a 32-bit AHB-Lite register port and a four-phase instruction cycle
package ilw_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int INSTR_CYCLE_NS = 200;
	localparam int CLKS_PER_CYCLE = INSTR_CYCLE_NS / CLK_PERIOD_NS;
	localparam logic [1:0] PHASE_ONE = 2'h0;
	localparam logic [1:0] PHASE_FOUR = 2'h3;

	// ****************************************************************
	// register offsets (byte addresses)
	// ****************************************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] PER_EN_OFS = 8'h04;
	localparam logic [7:0] FLAG_OFS = 8'h08;
	localparam logic [7:0] EV_STAT_OFS = 8'h0C;
	localparam logic [7:0] EV_CLR_OFS = 8'h10;
	localparam logic [7:0] EV_EN_OFS = 8'h14;
	localparam logic [7:0] SEQ_STAT_OFS = 8'h18;

	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int CTRL_GLOBAL_EN = 0;
	localparam int CTRL_EXT_EN = 1;
	localparam int CTRL_EDGE_SEL = 2;
	localparam int CTRL_PER_EN = 3;
	localparam int FLAG_EXT = 0;
	localparam int FLAG_PER_LSB = 8;
	localparam int EV_VECTOR = 0;
	localparam int EV_WAKE = 1;
	localparam int EV_EDGE = 2;
	localparam int EV_N = 3;
	localparam int SEQ_PEND = 4;
	localparam int SEQ_PHASE_LSB = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] VECTOR_ADDR = 16'h0004;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [2:0] {
		S_RUN, S_FLUSH, S_VECTOR, S_SLEEP, S_WAKE
	} ilw_seq_e;

	// what the core pipeline tells the sequencer
	typedef struct packed {
		logic sleep_req;
		logic ret_irq;
		logic [15:0] pc;
		logic [15:0] stack_top;
	} ilw_core_s;

	// what the sequencer tells the core pipeline
	typedef struct packed {
		logic flush;
		logic push;
		logic pop;
		logic pc_load;
		logic stall;
		logic sleep;
		logic [15:0] push_addr;
		logic [15:0] load_addr;
	} ilw_ctl_s;

endpackage

// >>> ilw_pin_edge.sv
// ilw_pin_edge: synchroniser and selectable edge detector for the pin
// assumes the pin is asynchronous to the system clock
`timescale 1ns/1ps
`default_nettype none
module ilw_pin_edge (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic pin_i,
	input wire logic rising_i,
	output logic edge_o
);
	logic meta;
	logic sync;
	logic prev;

	// ****************************************************************
	// two-stage synchroniser, then one stage of history
	// ****************************************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end else if (ce_i) begin
			meta <= pin_i; // read only by sync
			sync <= meta;
			prev <= sync;
		end
	end

	// edge of the selected polarity, from synchronised stages only
	assign edge_o = ce_i && (rising_i ? (sync && !prev) : (!sync && prev));

endmodule
`default_nettype wire

// >>> ilw_ahb_slave.sv
// ilw_ahb_slave: AHB-Lite front end with one wait state per transfer
// assumes single word transfers; the response is always OKAY
`timescale 1ns/1ps
`default_nettype none
module ilw_ahb_slave (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] rdata_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic wr_o,
	output logic [7:0] addr_o
);
	logic pend;
	logic write;

	// ****************************************************************
	// address phase capture and data phase completion
	// ****************************************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend <= 1'b0;
			write <= 1'b0;
			addr_o <= 8'h00;
			hreadyout_o <= 1'b1;
			hrdata_o <= 32'h0000_0000;
		end else if (ce_i) begin
			if (pend) begin
				pend <= 1'b0;
				hreadyout_o <= 1'b1; // data phase ends here
				hrdata_o <= write ? 32'h0000_0000 : rdata_i;
			end else if (hsel_i && htrans_i[1] && hready_i) begin
				pend <= 1'b1;
				write <= hwrite_i;
				addr_o <= haddr_i[7:0];
				hreadyout_o <= 1'b0; // one wait state
			end
		end
	end

	// write strobe in the first data phase cycle, when hwdata stands
	assign wr_o = ce_i && pend && write;

endmodule
`default_nettype wire

// >>> ilw_core_model.sv
// ilw_core_model: behavioural core pipeline facing the sequencer
// assumes CE is high and one instruction cycle of four clocks
`timescale 1ns/1ps
`default_nettype none
module ilw_core_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire ilw_pkg::ilw_ctl_s ctl_i,
	input wire logic [1:0] phase_i,
	input wire logic sleep_cmd_i,
	input wire logic ret_cmd_i,
	output ilw_pkg::ilw_core_s core_o
);
	logic [15:0] pc;
	logic [15:0] stk [8];
	logic [2:0] sp;
	logic step;

	// ****************************************************************
	// program counter and return stack
	// ****************************************************************
	// one instruction retires per cycle unless stalled or asleep
	assign step = (phase_i == ilw_pkg::PHASE_FOUR) && !ctl_i.stall &&
		!ctl_i.sleep;
	// an empty stack shows garbage, not the last address
	assign core_o.stack_top = (sp != 3'h0) ? stk[sp - 3'h1] : ~pc;
	// return address: the next instruction, the one a take flushes
	assign core_o.pc = pc + 16'h0001;
	assign core_o.sleep_req = sleep_cmd_i;
	assign core_o.ret_irq = ret_cmd_i;

	// stack moves and pc updates
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc <= 16'h0100;
			sp <= 3'h0;
		end else begin
			if (ctl_i.push) begin
				stk[sp] <= ctl_i.push_addr;
				sp <= sp + 3'h1;
			end else if (ctl_i.pop && sp != 3'h0) begin
				sp <= sp - 3'h1;
			end
			if (ctl_i.pc_load) begin
				pc <= ctl_i.load_addr;
			end else if (step) begin
				pc <= pc + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// >>> test_interrupt_latency_wake_ext_pin.sv
// test_interrupt_latency_wake_ext_pin: self-checking bench of ilw_seq
// assumes ilw_pkg, ilw_seq and ilw_core_model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
	$display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module test_interrupt_latency_wake_ext_pin;
	logic clk, rst_n, hsel, hwrite, pin, sleep_cmd, ret_cmd, rd_dp, ce;
	logic [1:0] htrans, e_ph;
	logic [31:0] haddr, hwdata, e_rd;
	logic [3:0] pflag;
	logic [15:0] ret_pc, e_ld;
	logic [31:0] rd_q [$];
	logic [15:0] ld_q [$];
	wire logic [31:0] hrdata;
	wire logic hready, irq, hresp;
	wire logic [1:0] phase;
	wire ilw_pkg::ilw_core_s core;
	wire ilw_pkg::ilw_ctl_s ctl;
	int fail_count = 0, n_tests = 0, seed = 2, cyc = 0, n_flush = 0;
	int t0, t_fl, t_w, nf, k;

	ilw_seq u_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce),
		.HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
		.HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata),
		.HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
		.HRESP_O(hresp), .EXT_PIN_I(pin), .PERIPH_FLAG_I(pflag),
		.CORE_I(core), .CTL_O(ctl), .PHASE_O(phase), .IRQ_O(irq));
	ilw_core_model u_core (.clk_i(clk), .rst_n_i(rst_n), .ctl_i(ctl),
		.phase_i(phase), .sleep_cmd_i(sleep_cmd), .ret_cmd_i(ret_cmd),
		.core_o(core));

	// ****************************************************************
	// clock, monitor and watchdog
	// ****************************************************************
	// 20 MHz system clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// oldest note is compared whenever read data or a pc load appears
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (ctl.flush === 1'b1) n_flush <= n_flush + 1;
		if (rd_dp && hready === 1'b1) begin
			e_rd = rd_q.pop_front();
			`CHK(hrdata, e_rd)
			`CHK(hresp, 1'b0)
		end
		if (ctl.pc_load === 1'b1) begin
			e_ld = ld_q.pop_front();
			`CHK(ctl.load_addr, e_ld)
		end
	end
	// hang guard
	initial begin
		#(20000 * 50);
		fail_count++;
		finish_test();
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic finish_test();
		$display("tests %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// one single AHB-Lite word transfer; read notes its expected data
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		if (!w) rd_q.push_back(d);
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		rd_dp <= !w;
		do @(posedge clk); while (hready !== 1'b1);
		rd_dp <= 1'b0;
	endtask
	// drive the pin after a random number of clocks
	task automatic kick(input logic lvl);
		repeat ($unsigned($random(seed)) % 4) @(posedge clk);
		pin <= lvl;
		t0 = cyc;
	endtask
	task automatic wait_fl();
		for (k = 0; k < 40 && ctl.flush !== 1'b1; k++) @(posedge clk);
		t_fl = cyc;
	endtask
	task automatic snooze();
		sleep_cmd <= 1'b1;
		for (k = 0; k < 20 && ctl.sleep !== 1'b1; k++) @(posedge clk);
		sleep_cmd <= 1'b0;
	endtask
	// vector entry, then service routine clears the flag and returns
	task automatic svc();
		`CHK(ctl.push_addr, u_core.pc)
		ret_pc = u_core.pc;
		ld_q.push_back(ilw_pkg::VECTOR_ADDR);
		repeat (8) @(posedge clk);
		`CHK(ctl.pc_load, 1'b1)
		bus(1'b0, ilw_pkg::CTRL_OFS, 32'h0000_0006);
		bus(1'b1, ilw_pkg::FLAG_OFS, 32'h0000_0001);
		ld_q.push_back(ret_pc);
		ret_cmd <= 1'b1;
		@(posedge clk);
		ret_cmd <= 1'b0;
		repeat (4) @(posedge clk);
		bus(1'b0, ilw_pkg::CTRL_OFS, 32'h0000_0007);
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{rst_n, hsel, hwrite, pin, sleep_cmd, ret_cmd, rd_dp} = '0;
		{htrans, haddr, hwdata, pflag} = '0;
		ce = 1'b1;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		bus(1'b0, ilw_pkg::CTRL_OFS, ilw_pkg::CTRL_RST);
		bus(1'b0, ilw_pkg::PER_EN_OFS, 32'h0000_0000);
		bus(1'b0, 8'h40, 32'h0000_0000);
		$display("test reset done");
		// both edge polarities, all enables clear
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, ilw_pkg::CTRL_OFS, {29'h0, 1'(4'b0011 >> i), 2'b00});
			bus(1'b1, ilw_pkg::FLAG_OFS, 32'h0000_0001);
			kick(1'(4'b0101 >> i));
			repeat (12) @(posedge clk);
			bus(1'b0, ilw_pkg::FLAG_OFS,
				32'(1'(4'b1001 >> i)));
		end
		`CHK(n_flush, 0)
		$display("test edge done");
		// taken interrupt latency at random pin phases
		for (int i = 0; i < 4; i++) begin
			kick(1'b0);
			bus(1'b1, ilw_pkg::FLAG_OFS, 32'h0000_0001);
			bus(1'b1, ilw_pkg::CTRL_OFS, 32'h0000_0007);
			kick(1'b1);
			wait_fl();
			`CHK(t_fl + 7 - t0 >= 12 && t_fl + 7 - t0 <= 20, 1'b1)
			svc();
		end
		$display("test vector done");
		// wake without vectoring; late enable and clocked source refused
		bus(1'b1, ilw_pkg::CTRL_OFS, 32'h0000_000C);
		bus(1'b1, ilw_pkg::PER_EN_OFS, 32'h0000_0003);
		kick(1'b0);
		bus(1'b1, ilw_pkg::FLAG_OFS, 32'h0000_0001);
		nf = n_flush;
		snooze();
		bus(1'b1, ilw_pkg::CTRL_OFS, 32'h0000_000E);
		kick(1'b1);
		pflag <= 4'b0010;
		repeat (20) @(posedge clk);
		`CHK(ctl.sleep, 1'b1)
		pflag <= 4'b0011;
		for (k = 0; k < 20 && ctl.sleep === 1'b1; k++) @(posedge clk);
		`CHK(ctl.sleep, 1'b0)
		repeat (20) @(posedge clk);
		`CHK(n_flush, nf)
		pflag <= 4'b0000;
		$display("test wake done");
		// wake with global enable: next instruction first, then vector
		bus(1'b1, ilw_pkg::PER_EN_OFS, 32'h0000_0000);
		kick(1'b0);
		bus(1'b1, ilw_pkg::FLAG_OFS, 32'h0000_0001);
		bus(1'b1, ilw_pkg::CTRL_OFS, 32'h0000_0007);
		snooze();
		kick(1'b1);
		for (k = 0; k < 20 && ctl.sleep === 1'b1; k++) @(posedge clk);
		t_w = cyc;
		wait_fl();
		`CHK(t_fl - t_w >= 4 && t_fl - t_w <= 12, 1'b1)
		svc();
		$display("test wake vector done");
		// event status, enable mask and clear drive the level interrupt
		bus(1'b1, ilw_pkg::CTRL_OFS, 32'h0000_0004);
		bus(1'b1, ilw_pkg::EV_CLR_OFS, 32'h0000_0007);
		bus(1'b1, ilw_pkg::EV_EN_OFS, 32'h0000_0004);
		kick(1'b0);
		kick(1'b1);
		repeat (12) @(posedge clk);
		`CHK(irq, 1'b1)
		bus(1'b0, ilw_pkg::EV_STAT_OFS, 32'h0000_0004);
		bus(1'b1, ilw_pkg::EV_EN_OFS, 32'h0000_0000);
		repeat (3) @(posedge clk);
		`CHK(irq, 1'b0)
		bus(1'b1, ilw_pkg::EV_EN_OFS, 32'h0000_0004);
		bus(1'b1, ilw_pkg::EV_CLR_OFS, 32'h0000_0004);
		repeat (3) @(posedge clk);
		`CHK(irq, 1'b0)
		bus(1'b0, ilw_pkg::EV_STAT_OFS, 32'h0000_0000);
		bus(1'b0, ilw_pkg::EV_CLR_OFS, 32'h0000_0000);
		$display("test events done");
		// clock enable low freezes the phase counter
		ce <= 1'b0;
		@(posedge clk);
		e_ph = phase;
		repeat (5) @(posedge clk);
		`CHK(phase, e_ph)
		ce <= 1'b1;
		$display("test enable done");
		finish_test();
	end
endmodule
`default_nettype wire
